// ### hw/scg_ctrl.sv
/*
 * Clock gating control for peripheral group 0: run, sleep and deep-sleep gate
 * registers, the converter rate select, unit clock enables and fault reporting.
 * Assumes a classic Wishbone master, a power-state input from the system power
 * controller, and unit access requests flagged by the system bus decoder.
 */
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module scg_ctrl
	import scg_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [11:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	output logic O_WB_ERR,
	input wire logic [1:0] I_POWER_STATE,
	input wire logic [1:0] I_RATE_MAX,
	input wire logic [2:0] I_UNIT_ACCESS,
	output logic [2:0] O_UNIT_FAULT,
	output logic O_WDOG_CLK_EN,
	output logic O_ADC_CLK_EN,
	output logic O_CAN_CLK_EN,
	output logic [1:0] O_ADC_RATE,
	output logic O_IRQ
);

	////////////////////////////////////////////////////////////////////////////////

	scg_wb_req_s req;
	scg_units_s units;
	scg_power_e pstate;
	logic [31:0] run_gate_reg;
	logic [31:0] sleep_gate_reg;
	logic [31:0] deep_sleep_gate_reg;
	logic [31:0] run_clock_config;
	logic [N_IRQ-1:0] irq_stat;
	logic [N_IRQ-1:0] irq_en;
	logic [2:0] last_fault;
	logic [1:0] prev_state;

	assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, adr: I_WB_ADR,
		sel: I_WB_SEL, dat: I_WB_DAT};
	assign pstate = scg_power_e'(I_POWER_STATE);

	// Byte-lane merge of a write into the writable bits only.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel, input logic [31:0] rw);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & rw;
		merge = (old & ~m) | (wd & m);
	endfunction

	// Clamps a requested sample rate to the permitted maximum.
	function automatic logic [1:0] clamp_rate(input logic [1:0] want, input logic [1:0] lim);
		clamp_rate = (want > lim) ? lim : want;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// A request is taken once; the standing answer blocks a second take of it.
	wire logic access = req.cyc & req.stb & ~O_WB_ACK & ~O_WB_ERR;
	// A write lands at the edge at which the master samples the acknowledge.
	wire logic wr = req.cyc & req.stb & req.we & O_WB_ACK;
	logic hit_run;
	logic hit_sleep;
	logic hit_deep;
	logic hit_cfg;
	logic hit_stat;
	logic hit_en;
	logic hit_clr;
	logic hit_acc;

	always_comb begin
		hit_run = 1'b0;
		hit_sleep = 1'b0;
		hit_deep = 1'b0;
		hit_cfg = 1'b0;
		hit_stat = 1'b0;
		hit_en = 1'b0;
		hit_clr = 1'b0;
		hit_acc = 1'b0;
		if (req.adr == RUN_GATE_OFF) begin
			hit_run = 1'b1;
		end else if (req.adr == SLEEP_GATE_OFF) begin
			hit_sleep = 1'b1;
		end else if (req.adr == DEEP_GATE_OFF) begin
			hit_deep = 1'b1;
		end else if (req.adr == RUN_CFG_OFF) begin
			hit_cfg = 1'b1;
		end else if (req.adr == IRQ_STAT_OFF) begin
			hit_stat = 1'b1;
		end else if (req.adr == IRQ_EN_OFF) begin
			hit_en = 1'b1;
		end else if (req.adr == IRQ_CLR_OFF) begin
			hit_clr = 1'b1;
		end else if (req.adr == ACCESS_OFF) begin
			hit_acc = 1'b1;
		end
	end

	wire logic mapped = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_en
		| hit_clr | hit_acc;

	////////////////////////////////////////////////////////////////////////////////
	// Active gate selection.

	wire logic auto_gate = run_clock_config[AUTO_GATE_BIT];
	logic [31:0] active_gate;

	always_comb begin
		active_gate = run_gate_reg;
		if (auto_gate) begin
			case (pstate)
				PS_SLEEP: begin
					active_gate = sleep_gate_reg;
				end
				PS_DEEP: begin
					active_gate = deep_sleep_gate_reg;
				end
				default: begin
					active_gate = run_gate_reg;
				end
			endcase
		end
	end

	// Only the three enable bits reach a unit enable; reserved bits are dropped.
	assign units = '{wdog: active_gate[WDOG_BIT], adc: active_gate[ADC_BIT],
		can: active_gate[CAN_BIT]};

	wire logic [1:0] rate_req = active_gate[RATE_HI:RATE_LO];
	wire logic [1:0] rate_eff = clamp_rate(rate_req, I_RATE_MAX);
	wire logic rate_clamped = rate_req > I_RATE_MAX;
	wire logic [2:0] unit_vec = {units.can, units.adc, units.wdog};
	wire logic [2:0] next_fault = I_UNIT_ACCESS & ~unit_vec;

	////////////////////////////////////////////////////////////////////////////////
	// Gate and configuration registers.

	logic [31:0] next_run_gate;
	logic [31:0] next_sleep_gate;
	logic [31:0] next_deep_gate;
	logic [31:0] next_run_cfg;

	always_comb begin
		next_run_gate = run_gate_reg;
		next_sleep_gate = sleep_gate_reg;
		next_deep_gate = deep_sleep_gate_reg;
		next_run_cfg = run_clock_config;
		if (wr && hit_run) begin
			next_run_gate = merge(run_gate_reg, req.dat, req.sel, GATE_RW_MASK);
		end
		if (wr && hit_sleep) begin
			next_sleep_gate = merge(sleep_gate_reg, req.dat, req.sel, GATE_RW_MASK);
		end
		// The deep-sleep copy has no rate field, so those bits stay zero.
		if (wr && hit_deep) begin
			next_deep_gate = merge(deep_sleep_gate_reg, req.dat, req.sel,
				GATE_RW_NORATE);
		end
		if (wr && hit_cfg) begin
			next_run_cfg = merge(run_clock_config, req.dat, req.sel,
				32'h0000_0001 << AUTO_GATE_BIT);
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			run_gate_reg <= GATE_RESET;
		end else begin
			run_gate_reg <= next_run_gate;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			sleep_gate_reg <= GATE_RESET;
		end else begin
			sleep_gate_reg <= next_sleep_gate;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			deep_sleep_gate_reg <= GATE_RESET;
		end else begin
			deep_sleep_gate_reg <= next_deep_gate;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			run_clock_config <= CFG_RESET;
		end else begin
			run_clock_config <= next_run_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event status and interrupt enable.

	wire logic [N_IRQ-1:0] irq_set = {pstate != scg_power_e'(prev_state), rate_clamped,
		|next_fault};
	wire logic [N_IRQ-1:0] irq_clr = (wr & hit_clr & req.sel[0]) ? req.dat[N_IRQ-1:0]
		: '0;

	// A new event wins over a clear that falls in the same cycle.
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			irq_en <= '0;
		end else if (wr && hit_en && req.sel[0]) begin
			irq_en <= req.dat[N_IRQ-1:0];
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			last_fault <= '0;
			prev_state <= 2'h0;
		end else begin
			prev_state <= I_POWER_STATE;
			if (|next_fault) begin
				last_fault <= next_fault;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data and bus answer.

	logic [31:0] rd;

	always_comb begin
		rd = 32'h0000_0000;
		if (hit_run) begin
			rd = run_gate_reg;
		end else if (hit_sleep) begin
			rd = sleep_gate_reg;
		end else if (hit_deep) begin
			rd = deep_sleep_gate_reg;
		end else if (hit_cfg) begin
			rd = run_clock_config;
		end else if (hit_stat) begin
			rd = {{(32-N_IRQ){1'b0}}, irq_stat};
		end else if (hit_en) begin
			rd = {{(32-N_IRQ){1'b0}}, irq_en};
		end else if (hit_acc) begin
			rd = {29'h0, last_fault};
		end
	end

	// The answer stands for one cycle; read data is zero outside it.
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_WB_ACK <= 1'b0;
			O_WB_ERR <= 1'b0;
			O_WB_DAT <= 32'h0000_0000;
		end else begin
			O_WB_ACK <= access & mapped;
			O_WB_ERR <= access & ~mapped;
			O_WB_DAT <= (access && !req.we) ? rd : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Unit clock enables, converter rate and faults.

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_WDOG_CLK_EN <= 1'b0;
			O_ADC_CLK_EN <= 1'b0;
			O_CAN_CLK_EN <= 1'b0;
		end else begin
			O_WDOG_CLK_EN <= units.wdog;
			O_ADC_CLK_EN <= units.adc;
			O_CAN_CLK_EN <= units.can;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_ADC_RATE <= RATE_125K;
		end else begin
			O_ADC_RATE <= rate_eff;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_UNIT_FAULT <= 3'h0;
		end else begin
			O_UNIT_FAULT <= next_fault;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_stat & irq_en);
		end
	end

endmodule

// ### hw/scg_pkg.sv
/*
 * Package for the group-0 sleep clock gating control: register offsets, field
 * positions, reset values, power states and the bus carrier structs.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package scg_pkg;
	localparam logic [11:0] RUN_GATE_OFF = 12'h100;
	localparam logic [11:0] SLEEP_GATE_OFF = 12'h110;
	localparam logic [11:0] DEEP_GATE_OFF = 12'h120;
	localparam logic [11:0] RUN_CFG_OFF = 12'h060;
	localparam logic [11:0] IRQ_STAT_OFF = 12'h130;
	localparam logic [11:0] IRQ_EN_OFF = 12'h134;
	localparam logic [11:0] IRQ_CLR_OFF = 12'h138;
	localparam logic [11:0] ACCESS_OFF = 12'h13C;
	localparam int WDOG_BIT = 3;
	localparam int RSV_ONE_BIT = 6;
	localparam int RATE_LO = 8;
	localparam int RATE_HI = 9;
	localparam int ADC_BIT = 16;
	localparam int CAN_BIT = 24;
	localparam int AUTO_GATE_BIT = 27;
	localparam logic [31:0] GATE_RESET = 32'h0000_0040;
	localparam logic [31:0] GATE_RW_MASK = 32'h0101_0308;
	localparam logic [31:0] GATE_RW_NORATE = 32'h0101_0008;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [1:0] RATE_1M = 2'h3;
	localparam logic [1:0] RATE_500K = 2'h2;
	localparam logic [1:0] RATE_250K = 2'h1;
	localparam logic [1:0] RATE_125K = 2'h0;
	localparam logic [1:0] RATE_MAX_DEFAULT = 2'h3;
	localparam int N_IRQ = 3;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_RATE_CLAMP = 1;
	localparam int IRQ_STATE_CHG = 2;
	localparam int N_UNIT = 3;

	typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_DEEP} scg_power_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} scg_wb_req_s;

	typedef struct packed {
		logic wdog;
		logic adc;
		logic can;
	} scg_units_s;
endpackage

// ### tb/scg_ctrl_asserts.sv
/* Checker for the group-0 clock gate control.
   Assumes a master that holds address and direction until ack. */
`timescale 1ns/1ps
module scg_ctrl_asserts
	import scg_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_WB_WE,
	input wire logic [11:0] I_WB_ADR,
	input wire logic [31:0] O_WB_DAT,
	input wire logic O_WB_ACK,
	input wire logic [1:0] I_RATE_MAX,
	input wire logic [2:0] I_UNIT_ACCESS,
	input wire logic [2:0] O_UNIT_FAULT,
	input wire logic O_WDOG_CLK_EN,
	input wire logic O_ADC_CLK_EN,
	input wire logic O_CAN_CLK_EN,
	input wire logic [1:0] O_ADC_RATE
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);
	wire logic rd_ack = O_WB_ACK && !I_WB_WE;
	wire logic gate_adr = I_WB_ADR == RUN_GATE_OFF || I_WB_ADR == SLEEP_GATE_OFF
		|| I_WB_ADR == DEEP_GATE_OFF;
	sequence s_wdog_off;
		I_UNIT_ACCESS[0] && !O_WDOG_CLK_EN && $stable(O_WDOG_CLK_EN);
	endsequence
	property p_wdog_fault;
		s_wdog_off |=> O_UNIT_FAULT[0];
	endproperty
	property p_wdog_on;
		I_UNIT_ACCESS[0] && O_WDOG_CLK_EN && $stable(O_WDOG_CLK_EN) |=> !O_UNIT_FAULT[0];
	endproperty
	property p_adc_fault;
		I_UNIT_ACCESS[1] && !O_ADC_CLK_EN && $stable(O_ADC_CLK_EN) |=> O_UNIT_FAULT[1];
	endproperty
	property p_can_fault;
		I_UNIT_ACCESS[2] && !O_CAN_CLK_EN && $stable(O_CAN_CLK_EN) |=> O_UNIT_FAULT[2];
	endproperty
	property p_rate;
		O_ADC_RATE <= $past(I_RATE_MAX);
	endproperty
	property p_deep_rd;
		rd_ack && I_WB_ADR == DEEP_GATE_OFF |-> O_WB_DAT[6] && O_WB_DAT[9:8] == 2'h0;
	endproperty
	property p_rsv;
		rd_ack && gate_adr |-> (O_WB_DAT & ~GATE_RW_MASK) == GATE_RESET;
	endproperty
	property p_reset;
		disable iff (1'b0) !I_RST_B |=> !O_WDOG_CLK_EN && !O_ADC_CLK_EN && !O_CAN_CLK_EN;
	endproperty
	a_wdog_fault: assert property (p_wdog_fault) else $error("no fault on gated watchdog");
	a_wdog_on: assert property (p_wdog_on) else $error("fault on clocked watchdog");
	a_adc_fault: assert property (p_adc_fault) else $error("no fault on gated converter");
	a_can_fault: assert property (p_can_fault) else $error("no fault on gated controller");
	a_rate: assert property (p_rate) else $error("rate above permitted maximum");
	a_deep_rd: assert property (p_deep_rd) else $error("deep gate fixed bits wrong");
	a_rsv: assert property (p_rsv) else $error("reserved gate bits wrong");
	a_reset: assert property (p_reset) else $error("clock enable set in reset");
endmodule
bind scg_ctrl scg_ctrl_asserts u_scg_ctrl_asserts (.*);

// ### tb/scg_tb.sv
/* Testbench for the group-0 clock gate control.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module tb;
	import scg_pkg::*;
	logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, err, q_err, en_w, en_a, en_c, irq;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [1:0] pst = 0, pmax = 2'h2, rate;
	logic [2:0] acc = 0, flt;
	int n_mismatch = 0, compares = 0;
	scg_ctrl u_scg_ctrl (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wd), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .O_WB_ERR(err), .I_POWER_STATE(pst), .I_RATE_MAX(pmax),
		.I_UNIT_ACCESS(acc), .O_UNIT_FAULT(flt), .O_WDOG_CLK_EN(en_w), .O_ADC_CLK_EN(en_a),
		.O_CAN_CLK_EN(en_c), .O_ADC_RATE(rate), .O_IRQ(irq));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic stop_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One classic cycle; a read that does not end in an error is compared against e.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, e);
		int n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		q = rdat;
		q_err = err;
		{cyc, stb} <= 2'h0;
		if (n >= 20) n_mismatch++;
		if (!w && err !== 1'b1) chk(q, e);
	endtask
	task automatic w3;
		repeat (3) @(posedge clk);
	endtask
	task automatic poke;
		acc <= 3'h7;
		@(posedge clk);
		acc <= 3'h0;
		@(negedge clk);
	endtask
	// Whole run is about a hundred cycles; this cuts a hang short.
	initial begin
		#100000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, RUN_GATE_OFF, 0, GATE_RESET);
		bus(1'b0, SLEEP_GATE_OFF, 0, GATE_RESET);
		bus(1'b0, DEEP_GATE_OFF, 0, GATE_RESET);
		bus(1'b0, 12'h004, 0, 0);
		chk(q_err, 1);
		bus(1'b1, IRQ_EN_OFF, 32'h0000_0001, 0);
		poke;
		chk(flt, 3'h7);
		@(negedge clk);
		chk(irq, 1);
		bus(1'b0, ACCESS_OFF, 0, 32'h0000_0007);
		bus(1'b1, IRQ_CLR_OFF, 32'h0000_0001, 0);
		w3;
		chk(irq, 0);
		bus(1'b1, RUN_GATE_OFF, 32'hFFFF_FFFF, 0);
		bus(1'b0, RUN_GATE_OFF, 0, 32'h0101_0348);
		w3;
		chk({en_w, en_a, en_c}, 3'h7);
		chk(rate, RATE_500K);
		pmax <= RATE_1M;
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, RUN_GATE_OFF, 32'h0101_0008 | (r << 8), 0);
			w3;
			chk(rate, r[1:0]);
		end
		bus(1'b0, RUN_GATE_OFF, 0, 32'h0101_0348);
		bus(1'b1, RUN_GATE_OFF, q, 0);
		bus(1'b0, RUN_GATE_OFF, 0, 32'h0101_0348);
		bus(1'b1, DEEP_GATE_OFF, 32'hFFFF_FFFF, 0);
		bus(1'b0, DEEP_GATE_OFF, 0, 32'h0101_0048);
		bus(1'b1, SLEEP_GATE_OFF, 32'h0100_0000, 0);
		bus(1'b1, DEEP_GATE_OFF, 32'h0001_0000, 0);
		pst <= 2'h1;
		w3;
		chk({en_w, en_a, en_c}, 3'h7);
		bus(1'b1, RUN_CFG_OFF, 32'h0800_0000, 0);
		w3;
		chk({en_w, en_a, en_c}, 3'h1);
		pst <= 2'h2;
		w3;
		chk({en_w, en_a, en_c}, 3'h2);
		poke;
		chk(flt, 3'h5);
		bus(1'b0, IRQ_STAT_OFF, 0, 32'h0000_0007);
		stop_test;
	end
endmodule
